// ---- logic/exec_regs.svh ----
// Purpose: opcode, field and register-port constants of the executor
// Assumes: byte-addressed register file, 24-bit code addresses
// Notes: register offsets are byte addresses on the local port
`ifndef EXEC_REGS_SVH
`define EXEC_REGS_SVH
`define OPC_PREFIX   8'hA5
`define OPC_DIV_B    8'h8C
`define OPC_DIV_W    8'h8D
`define OPC_DIV_AB   8'h84
`define OPC_DECREMENT_BRANCH_OP_DIR 8'hD5
`define OPC_DECREMENT_BRANCH_OP_RN  5'h1B
`define OPC_CALL_ABS 8'h9A
`define OPC_CALL_IND 8'h99
`define CALL_RET_ADD 24'h000004
`define SP_STEP      16'h0001
`define PUSH_LAST    2'h2
`define REG_CTRL     4'h0
`define REG_STATUS   4'h4
`define REG_TARGET   4'h8
`define CTRL_SRC_BIT 0
`define CTRL_RST     1'b0
`define ST_BUSY_BIT  0
`define ST_DZ_BIT    1
`define ST_TAKEN_BIT 2
`define ST_ILL_BIT   3
`endif

// ---- logic/exec_pkg.sv ----
// Purpose: types shared by the executor and its divider
// Assumes: nothing beyond the constants header
// Notes: structs group each strobe with its data
package exec_pkg;
    typedef enum logic [7:0] {
        S_IDLE  = 8'h01,
        S_RD_A  = 8'h02,
        S_RD_B  = 8'h04,
        S_START = 8'h08,
        S_DIV   = 8'h10,
        S_DJ_RD = 8'h20,
        S_DJ_WR = 8'h40,
        S_PUSH  = 8'h80
    } exec_state_e;
    typedef enum logic [2:0] {
        OP_DIV_B, OP_DIV_W, OP_DIV_AB, OP_DECREMENT_BRANCH_OP_D, OP_DECREMENT_BRANCH_OP_R, OP_CALL_A, OP_CALL_I
    } exec_op_e;
    typedef struct packed {logic [4:0][7:0] b; logic [23:0] pc;} instr_s;
    typedef struct packed {logic en; logic [5:0] addr;} rf_rd_s;
    typedef struct packed {logic en; logic [5:0] addr; logic [3:0] be; logic [31:0] data;} rf_wr_s;
    typedef struct packed {logic en; logic from_latch; logic [7:0] addr;} dm_rd_s;
    typedef struct packed {logic en; logic [7:0] addr; logic [7:0] data;} dm_wr_s;
    typedef struct packed {logic en; logic [15:0] addr; logic [7:0] data;} stk_wr_s;
    typedef struct packed {logic en; logic [7:0] acc; logic [7:0] aux;} ab_wr_s;
    typedef struct packed {logic cy_we, cy, ov_we, ov, n_we, n, z_we, z;} flag_wr_s;
    typedef struct packed {logic en; logic [15:0] val;} sp_upd_s;
    typedef struct packed {logic en; logic [23:0] val;} pc_upd_s;
endpackage

// ---- logic/udiv_seq.sv ----
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: start is a one-cycle pulse while idle
// Notes: a zero divisor gives all-ones quotient; callers treat it as undefined
`timescale 1ns/100ps
module udiv_seq import exec_pkg::*; #(
    parameter int W = 16
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    output logic              done,
    output logic [W-1:0]      quot,
    output logic [W-1:0]      rem
);
    localparam int CW = $clog2(W + 1);
    logic [W-1:0]  rem_q;
    logic [W-1:0]  quot_q;
    logic [W-1:0]  dvs_q;
    logic [CW-1:0] cnt_q;
    logic          busy_q;
    logic          done_q;
    logic [W:0]    trial;

    if (W < 2) begin : g_bad_width
        $error("udiv_seq needs W of at least 2");
    end

    // borrow out of bit W means the shifted remainder is below the divisor
    assign trial = {rem_q, quot_q[W-1]} - {1'b0, dvs_q};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rem_q  <= '0;
            quot_q <= '0;
            dvs_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= busy_q && (cnt_q == CW'(1));
            if (start) begin
                rem_q  <= '0;
                quot_q <= dividend;
                dvs_q  <= divisor;
                cnt_q  <= CW'(W);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q  <= trial[W] ? {rem_q[W-2:0], quot_q[W-1]} : trial[W-1:0];
                quot_q <= {quot_q[W-2:0], ~trial[W]};
                cnt_q  <= cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    assign done = done_q;
    assign quot = quot_q;
    assign rem  = rem_q;
endmodule // udiv_seq

// ---- logic/divide_loop_extcall_exec.sv ----
// Purpose: executes register divide, accumulator divide, decrement-branch and extended call
// Assumes: core holds the register file, data memory, stack RAM, program counter and flags
// Notes: result strobes are one-cycle pulses beside done, save the first two stack pushes of a call; one instruction at a time
// Behaviour
// - register divide unsigned, clears carry, clears overflow unless divisor zero
// - byte divide yields 16-bit quotient/remainder pair
// - even destination gets remainder, odd gets quotient
// - word divide placement keyed on index modulo four
// - negative and zero flags follow the quotient
// - zero register divisor sets overflow, clears carry
// - accumulator divided by auxiliary, quotient and remainder
// - zero auxiliary divisor sets overflow, clears carry
// - register divide and call need prefix in binary mode
// - byte divide opcode 8C plus register byte
// - word divide opcode 8D plus register byte
// - decrement wraps, branch only on nonzero result
// - branch target is next address plus displacement
// - port decrement reads the output latch
// - decrement-branch opcodes D5 and D8-DF, no prefix
// - call pushes return address four on, SP plus three
// - pre-increment SP, push high byte first
// - absolute call loads 24-bit address, high first
// - call target anywhere, flags untouched
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "exec_regs.svh"
module divide_loop_extcall_exec import exec_pkg::*; #(
    parameter int DIV_W = 16
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        ins_valid,
    input  wire instr_s      ins,
    output logic             ins_ready,
    input  wire logic [7:0]  acc_in,
    input  wire logic [7:0]  aux_in,
    input  wire logic [15:0] sp_in,
    input  wire logic [31:0] rf_rdata,
    input  wire logic [7:0]  dm_rdata,
    output rf_rd_s           rf_rd,
    output rf_wr_s           rf_wr,
    output dm_rd_s           dm_rd,
    output dm_wr_s           dm_wr,
    output stk_wr_s          stk_wr,
    output ab_wr_s           ab_wr,
    output flag_wr_s         flag_wr,
    output sp_upd_s          sp_upd,
    output pc_upd_s          pc_upd,
    output logic             done,
    output logic             illegal
);
    if (DIV_W != 16) begin : g_bad_width
        $error("divide_loop_extcall_exec serves only a 16-bit divider");
    end

    exec_state_e state_q;
    exec_op_e    op_q;
    exec_op_e    dec_op;
    logic        src_mode_q;
    logic [7:0]  fld_q;
    logic [7:0]  rel_q;
    logic [23:0] next_pc_q;
    logic [23:0] ret_q;
    logic [23:0] tgt_q;
    logic [15:0] ptr_q;
    logic [15:0] ptr_n;
    logic [1:0]  cnt_q;
    logic [15:0] dvs_q;
    logic        dz_q;
    logic        taken_q;
    logic        ill_q;
    logic        pfx;
    logic        ext_ok;
    logic        dec_ok;
    logic [7:0]  opc;
    logic [7:0]  fld;
    logic [2:0]  len;
    logic        accept;
    logic        div_start;
    logic        div_done;
    logic [15:0] div_a;
    logic [15:0] div_b;
    logic [15:0] quot;
    logic [15:0] rem;
    logic [7:0]  dj_old;
    logic [7:0]  dj_new;
    logic [23:0] dj_tgt;
    logic        div_fin;
    logic        is_div;
    logic        is_call;

    always_comb begin
        pfx    = (ins.b[0] == `OPC_PREFIX) && !src_mode_q;
        opc    = pfx ? ins.b[1] : ins.b[0];
        fld    = pfx ? ins.b[2] : ins.b[1];
        ext_ok = src_mode_q || pfx;
        dec_ok = 1'b1;
        dec_op = OP_DIV_AB;
        len    = 3'h1;
        if (ext_ok && opc == `OPC_DIV_B) begin
            dec_op = OP_DIV_B;
            len    = 3'h2;
        end else if (ext_ok && opc == `OPC_DIV_W) begin
            dec_op = OP_DIV_W;
            len    = 3'h2;
        end else if (ext_ok && opc == `OPC_CALL_ABS) begin
            dec_op = OP_CALL_A;
            len    = 3'h4;
        end else if (ext_ok && opc == `OPC_CALL_IND) begin
            dec_op = OP_CALL_I;
            len    = 3'h2;
        end else if (!pfx && opc == `OPC_DECREMENT_BRANCH_OP_DIR) begin
            dec_op = OP_DECREMENT_BRANCH_OP_D;
            len    = 3'h3;
        end else if (!pfx && opc[7:3] == `OPC_DECREMENT_BRANCH_OP_RN) begin
            dec_op = OP_DECREMENT_BRANCH_OP_R;
            len    = 3'h2;
        end else if (!pfx && opc == `OPC_DIV_AB) begin
            dec_op = OP_DIV_AB;
        end else begin
            dec_ok = 1'b0;
        end
    end

    assign ins_ready = (state_q == S_IDLE);
    assign accept    = ins_ready && ins_valid;
    assign is_div    = (op_q == OP_DIV_B) || (op_q == OP_DIV_W) || (op_q == OP_DIV_AB);
    assign is_call   = (op_q == OP_CALL_A) || (op_q == OP_CALL_I);
    assign div_fin   = (state_q == S_DIV) && div_done;
    assign div_start = (state_q == S_START);
    assign ptr_n     = ptr_q + `SP_STEP;

    // read strobes decode straight from state so data lands in the next state
    always_comb begin
        rf_rd = '0;
        dm_rd = '0;
        if (state_q == S_RD_A) begin
            rf_rd.en = 1'b1;
            case (op_q)
                OP_DIV_B: rf_rd.addr = {2'h0, fld_q[3:0]};
                OP_DIV_W: rf_rd.addr = {1'b0, fld_q[3:0], 1'b0};
                default:  rf_rd.addr = {fld_q[7:4], 2'h0};
            endcase
        end else if (state_q == S_RD_B) begin
            rf_rd.en   = !is_call;
            rf_rd.addr = (op_q == OP_DIV_B) ? {2'h0, fld_q[7:4]} : {1'b0, fld_q[7:4], 1'b0};
        end else if (state_q == S_DJ_RD) begin
            rf_rd.en         = (op_q == OP_DECREMENT_BRANCH_OP_R);
            rf_rd.addr       = {3'h0, fld_q[2:0]};
            dm_rd.en         = (op_q == OP_DECREMENT_BRANCH_OP_D);
            dm_rd.from_latch = 1'b1;
            dm_rd.addr       = fld_q;
        end
    end

    // byte operands are zero-extended; the divider is unsigned throughout
    always_comb begin
        case (op_q)
            OP_DIV_AB: div_a = {8'h00, acc_in};
            OP_DIV_B:  div_a = {8'h00, rf_rdata[31:24]};
            default:   div_a = rf_rdata[31:16];
        endcase
        div_b = (op_q == OP_DIV_AB) ? {8'h00, aux_in} : dvs_q;
    end

    udiv_seq #(
        .W (DIV_W)
    ) u_div (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .start    (div_start),
        .dividend (div_a),
        .divisor  (div_b),
        .done     (div_done),
        .quot     (quot),
        .rem      (rem)
    );

    assign dj_old = (op_q == OP_DECREMENT_BRANCH_OP_R) ? rf_rdata[31:24] : dm_rdata;
    assign dj_new = dj_old - 8'h01;
    assign dj_tgt = next_pc_q + {{16{rel_q[7]}}, rel_q};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_mode_q <= `CTRL_RST;
            reg_rdata  <= 32'h0000_0000;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL) begin
                src_mode_q <= reg_wdata[`CTRL_SRC_BIT];
            end
            reg_rdata <= 32'h0000_0000;
            if (reg_rd) begin
                case (reg_addr)
                    `REG_CTRL:   reg_rdata[`CTRL_SRC_BIT] <= src_mode_q;
                    `REG_STATUS: reg_rdata[3:0] <= {ill_q, taken_q, dz_q, !ins_ready};
                    `REG_TARGET: reg_rdata[23:0] <= pc_upd.val;
                    default:     reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q   <= S_IDLE;
            op_q      <= OP_DIV_AB;
            fld_q     <= 8'h00;
            rel_q     <= 8'h00;
            next_pc_q <= 24'h00_0000;
            ret_q     <= 24'h00_0000;
            tgt_q     <= 24'h00_0000;
            ptr_q     <= 16'h0000;
            cnt_q     <= 2'h0;
            dvs_q     <= 16'h0000;
            dz_q      <= 1'b0;
        end else begin
            case (state_q)
                S_IDLE: if (accept && dec_ok) begin
                    op_q      <= dec_op;
                    fld_q     <= (dec_op == OP_DECREMENT_BRANCH_OP_R) ? opc : fld;
                    rel_q     <= (dec_op == OP_DECREMENT_BRANCH_OP_R) ? fld : ins.b[2];
                    next_pc_q <= ins.pc + {21'h0, len} + {23'h0, pfx};
                    ret_q     <= ins.pc + {23'h0, pfx} + `CALL_RET_ADD;
                    tgt_q     <= pfx ? {ins.b[2], ins.b[3], ins.b[4]} : {ins.b[1], ins.b[2], ins.b[3]};
                    ptr_q     <= sp_in;
                    cnt_q     <= 2'h0;
                    case (dec_op)
                        OP_DIV_AB:             state_q <= S_START;
                        OP_DECREMENT_BRANCH_OP_D, OP_DECREMENT_BRANCH_OP_R:  state_q <= S_DJ_RD;
                        OP_CALL_A:             state_q <= S_PUSH;
                        default:               state_q <= S_RD_A;
                    endcase
                end
                // register data lands a cycle after its read strobe
                S_RD_A: state_q <= S_RD_B;
                S_RD_B: begin
                    if (op_q == OP_CALL_I) begin
                        tgt_q   <= rf_rdata[23:0];
                        state_q <= S_PUSH;
                    end else begin
                        dvs_q   <= (op_q == OP_DIV_B) ? {8'h00, rf_rdata[31:24]} : rf_rdata[31:16];
                        state_q <= S_START;
                    end
                end
                S_START: begin
                    dz_q    <= (div_b == 16'h0000);
                    state_q <= S_DIV;
                end
                S_DIV:   if (div_done) state_q <= S_IDLE;
                S_DJ_RD: state_q <= S_DJ_WR;
                S_DJ_WR: state_q <= S_IDLE;
                S_PUSH: begin
                    ptr_q <= ptr_n;
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == `PUSH_LAST) state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rf_wr   <= '0;
            dm_wr   <= '0;
            stk_wr  <= '0;
            ab_wr   <= '0;
            flag_wr <= '0;
            sp_upd  <= '0;
            pc_upd  <= '0;
            done    <= 1'b0;
            illegal <= 1'b0;
            taken_q <= 1'b0;
            ill_q   <= 1'b0;
        end else begin
            rf_wr.en   <= 1'b0;
            dm_wr.en   <= 1'b0;
            stk_wr.en  <= 1'b0;
            ab_wr.en   <= 1'b0;
            flag_wr    <= '0;
            sp_upd.en  <= 1'b0;
            pc_upd.en  <= 1'b0;
            done       <= 1'b0;
            illegal    <= accept && !dec_ok;
            if (accept) ill_q <= !dec_ok;
            if (div_fin) begin
                done          <= 1'b1;
                pc_upd        <= {1'b1, next_pc_q};
                flag_wr.cy_we <= 1'b1;
                flag_wr.ov_we <= 1'b1;
                flag_wr.ov    <= dz_q;
                flag_wr.n_we  <= 1'b1;
                flag_wr.z_we  <= 1'b1;
                if (op_q == OP_DIV_W) begin
                    flag_wr.n <= quot[15];
                    flag_wr.z <= (quot == 16'h0000);
                    // remainder word always at the four-aligned base, quotient in the word above it
                    rf_wr <= {1'b1, 1'b0, fld_q[7:5], 2'h0, 4'hF, rem, quot};
                end else begin
                    flag_wr.n <= quot[7];
                    flag_wr.z <= (quot[7:0] == 8'h00);
                    if (op_q == OP_DIV_AB) begin
                        ab_wr <= {1'b1, quot[7:0], rem[7:0]};
                    end else begin
                        rf_wr <= {1'b1, 2'h0, fld_q[7:5], 1'b0, 4'hC, rem[7:0], quot[7:0], 16'h0000};
                    end
                end
            end
            if (state_q == S_DJ_WR) begin
                done         <= 1'b1;
                taken_q      <= (dj_new != 8'h00);
                pc_upd       <= {1'b1, (dj_new != 8'h00) ? dj_tgt : next_pc_q};
                flag_wr.n_we <= 1'b1;
                flag_wr.n    <= dj_new[7];
                flag_wr.z_we <= 1'b1;
                flag_wr.z    <= (dj_new == 8'h00);
                if (op_q == OP_DECREMENT_BRANCH_OP_R) begin
                    rf_wr <= {1'b1, 3'h0, fld_q[2:0], 4'h8, dj_new, 24'h00_0000};
                end else begin
                    dm_wr <= {1'b1, fld_q, dj_new};
                end
            end
            if (state_q == S_PUSH) begin
                stk_wr.en   <= 1'b1;
                stk_wr.addr <= ptr_n;
                case (cnt_q)
                    2'h0:    stk_wr.data <= ret_q[23:16];
                    2'h1:    stk_wr.data <= ret_q[15:8];
                    default: stk_wr.data <= ret_q[7:0];
                endcase
                if (cnt_q == `PUSH_LAST) begin
                    done   <= 1'b1;
                    sp_upd <= {1'b1, ptr_n};
                    pc_upd <= {1'b1, tgt_q};
                end
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_div_carry_clear: assert property (done && is_div |-> flag_wr.cy_we && !flag_wr.cy && flag_wr.ov_we)
        else $error("divide did not clear carry");
    a_div_zero_ovf: assert property (done && is_div |-> flag_wr.ov == dz_q)
        else $error("divide overflow does not follow zero divisor");
    a_word_div_flags: assert property (done && op_q == OP_DIV_W && !dz_q
        |-> flag_wr.z == (rf_wr.data[15:0] == 16'h0000) && flag_wr.n == rf_wr.data[15])
        else $error("word divide flags disagree with quotient");
    a_byte_div_place: assert property (done && op_q == OP_DIV_B
        |-> rf_wr.en && rf_wr.be == 4'hC && !rf_wr.addr[0] && flag_wr.n == rf_wr.data[23])
        else $error("byte divide result misplaced");
    a_word_div_place: assert property (done && op_q == OP_DIV_W |-> rf_wr.en && rf_wr.addr[1:0] == 2'h0)
        else $error("word divide base not four-aligned");
    a_ab_div_result: assert property (div_fin && op_q == OP_DIV_AB |=> ab_wr.en && !rf_wr.en && done)
        else $error("accumulator divide result missing");
    a_decrement_branch_op_fallthru: assert property (done && (op_q == OP_DECREMENT_BRANCH_OP_D || op_q == OP_DECREMENT_BRANCH_OP_R) && flag_wr.z
        |-> pc_upd.val == next_pc_q && !taken_q)
        else $error("zero result still branched");
    a_decrement_branch_op_latch_rd: assert property (state_q == S_DJ_RD && op_q == OP_DECREMENT_BRANCH_OP_D
        |-> dm_rd.en && dm_rd.from_latch)
        else $error("port decrement did not read latch");
    a_push_order: assert property (stk_wr.en && $past(stk_wr.en)
        |-> stk_wr.addr == $past(stk_wr.addr) + 16'h0001)
        else $error("push addresses not consecutive");
    a_call_sp_three: assert property (done && is_call
        |-> sp_upd.en && sp_upd.val == stk_wr.addr && stk_wr.data == ret_q[7:0] && $past(stk_wr.en, 2))
        else $error("call did not push three bytes");
    a_call_flags_kept: assert property (state_q == S_PUSH |=> flag_wr == '0)
        else $error("call touched flags");

    c_byte_div: cover property (done && op_q == OP_DIV_B && !dz_q);
    c_div_zero: cover property (done && is_div && dz_q);
    c_decrement_branch_op_taken: cover property (done && op_q == OP_DECREMENT_BRANCH_OP_R && taken_q);
    c_call_ind: cover property (done && op_q == OP_CALL_I);
endmodule // divide_loop_extcall_exec

// ---- testbench/divide_loop_extcall_exec_tb.sv ----
// Purpose: self-checking bench for the divide, decrement-branch and extended call executor
// Assumes: bench models register file, direct bytes and stack; byte 0 of an instruction is rightmost
// Notes: released read data is inverted each cycle so stale values never pass
`timescale 1ns/100ps
`include "exec_regs.svh"
module divide_loop_extcall_exec_tb import exec_pkg::*;;
    logic        mclk, rst_n, reg_wr, reg_rd, ins_valid, ins_ready, done, illegal;
    logic [3:0]  reg_addr, f;
    logic [31:0] reg_wdata, reg_rdata, rf_rdata, d;
    logic [7:0]  acc_in, aux_in, dm_rdata;
    logic [15:0] sp_in, spv, abv;
    logic [23:0] pcv;
    instr_s      ins;
    rf_rd_s      rf_rd;
    rf_wr_s      rf_wr;
    dm_rd_s      dm_rd;
    dm_wr_s      dm_wr;
    stk_wr_s     stk_wr;
    ab_wr_s      ab_wr;
    flag_wr_s    flag_wr;
    sp_upd_s     sp_upd;
    pc_upd_s     pc_upd;
    logic [7:0]  rf[64], dm[256], stk[256];
    int          bad_count, compares, fwc, k, fw0;

    divide_loop_extcall_exec #(.DIV_W(16)) divide_loop_extcall_exec_inst (.mclk, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ins_valid, .ins, .ins_ready, .acc_in, .aux_in,
        .sp_in, .rf_rdata, .dm_rdata, .rf_rd, .rf_wr, .dm_rd, .dm_wr, .stk_wr, .ab_wr, .flag_wr,
        .sp_upd, .pc_upd, .done, .illegal);

    always #5 mclk = ~mclk;

    // far-side memories; writes land at the edge that carries the strobe
    always @(posedge mclk) begin
        rf_rdata <= rf_rd.en ? {rf[rf_rd.addr], rf[rf_rd.addr+1], rf[rf_rd.addr+2], rf[rf_rd.addr+3]} : ~rf_rdata;
        dm_rdata <= dm_rd.en ? dm[dm_rd.addr] : ~dm_rdata;
        if (dm_rd.en) chk("from_latch", 32'h1, {31'h0, dm_rd.from_latch});
        if (rf_wr.en) begin
            for (k = 0; k < 4; k++) if (rf_wr.be[3-k]) rf[rf_wr.addr+k] = rf_wr.data[31-8*k -: 8];
        end
        if (dm_wr.en) dm[dm_wr.addr] = dm_wr.data;
        if (stk_wr.en) stk[stk_wr.addr[7:0]] = stk_wr.data;
        if (flag_wr.cy_we) f[3] = flag_wr.cy;
        if (flag_wr.ov_we) f[2] = flag_wr.ov;
        if (flag_wr.n_we) f[1] = flag_wr.n;
        if (flag_wr.z_we) f[0] = flag_wr.z;
        if (flag_wr.cy_we | flag_wr.ov_we | flag_wr.n_we | flag_wr.z_we) fwc++;
        if (pc_upd.en) pcv = pc_upd.val;
        if (sp_upd.en) spv = sp_upd.val;
        if (ab_wr.en) abv = {ab_wr.acc, ab_wr.aux};
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic close_out();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic go(input string n, input logic [39:0] b, input logic [23:0] p, input logic il);
        int t;
        logic s;
        f = 'x;
        t = 0;
        @(posedge mclk);
        ins <= {b, p}; ins_valid <= 1'b1;
        @(posedge mclk);
        while (ins_ready !== 1'b1 && t < 50) begin @(posedge mclk); t++; end
        ins_valid <= 1'b0;
        if (ins_ready !== 1'b1) begin bad_count++; $display("timeout in %s", n); close_out(); end
        t = 0;
        do begin @(posedge mclk); t++; end while (done !== 1'b1 && illegal !== 1'b1 && t < 60);
        // pulse read before this edge's update lands; it is gone a step later
        s = illegal;
        if (t >= 60) begin bad_count++; $display("timeout in %s", n); close_out(); end
        #1 chk({n, "_illegal"}, {31'h0, il}, {31'h0, s});
        $display("test %s done", n);
    endtask

    initial begin
        mclk = 0; rst_n = 0; reg_addr = 0; reg_wdata = 0; reg_wr = 0; reg_rd = 0; ins_valid = 0;
        ins = '0; acc_in = 0; aux_in = 0; sp_in = 0; rf_rdata = 0; dm_rdata = 0;
        bad_count = 0; compares = 0; fwc = 0;
        foreach (rf[i]) rf[i] = 8'h00;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        rd(`REG_CTRL, d); chk("ctrl_reset", 32'h0, d);
        wr(`REG_CTRL, 32'h1); rd(`REG_CTRL, d); chk("ctrl", 32'h1, d);
        rd(4'hC, d); chk("unmapped", 32'h0, d);
        // source mode: no prefix needed
        rf[1] = 8'hFB; rf[5] = 8'h12;
        go("div_b_odd", 40'h158C, 24'h000100, 1'b0);
        chk("div_b_odd", 32'h110D, {rf[0], rf[1]});
        chk("div_b_flags", 32'h0, f);
        rf[2] = 8'h80; rf[7] = 8'h01;
        go("div_b_even", 40'h278C, 24'h000100, 1'b0);
        chk("div_b_even", 32'h0080, {rf[2], rf[3]});
        chk("div_b_neg", 32'h2, f);
        rf[6] = 8'h00;
        go("div_zero", 40'h468C, 24'h000100, 1'b0);
        chk("div_zero_flags", 32'h1, f[3:2]);
        rd(`REG_STATUS, d); chk("status_dz", 32'h1, d[`ST_DZ_BIT]);
        rf[4] = 8'h12; rf[5] = 8'h34; rf[8] = 8'h00; rf[9] = 8'h10;
        go("div_w4", 40'h248D, 24'h000100, 1'b0);
        chk("div_w4", 32'h00040123, {rf[4], rf[5], rf[6], rf[7]});
        chk("div_w_flags", 32'h0, f);
        rf[6] = 8'h01; rf[7] = 8'h05;
        go("div_w6", 40'h348D, 24'h000100, 1'b0);
        chk("div_w6", 32'h00050010, {rf[4], rf[5], rf[6], rf[7]});
        @(posedge mclk); acc_in <= 8'hFB; aux_in <= 8'h12;
        go("div_ab", 40'h84, 24'h000100, 1'b0);
        chk("div_ab", 32'h0D11, abv);
        chk("div_ab_flags", 32'h0, f);
        @(posedge mclk); aux_in <= 8'h00;
        go("div_ab_zero", 40'h84, 24'h000100, 1'b0);
        chk("div_ab_zero", 32'h1, f[3:2]);
        rf[9] = 8'hAB; rf[10] = 8'hCD; rf[11] = 8'hEF;
        @(posedge mclk); sp_in <= 16'h0020;
        fw0 = fwc;
        go("call_ind", 40'h2099, 24'h000100, 1'b0);
        chk("call_ind_pc", 32'hABCDEF, pcv);
        chk("call_ind_sp", 32'h0023, spv);
        chk("call_ind_stk", 32'h000104, {stk[8'h21], stk[8'h22], stk[8'h23]});
        // binary mode: prefix now required
        wr(`REG_CTRL, 32'h0);
        go("div_noprefix", 40'h158C, 24'h000100, 1'b1);
        rd(`REG_STATUS, d); chk("status_ill", 32'h1, d[`ST_ILL_BIT]);
        @(posedge mclk); sp_in <= 16'h0007;
        go("call_abs", 40'h5634129AA5, 24'h054321, 1'b0);
        chk("call_abs_pc", 32'h123456, pcv);
        chk("call_abs_sp", 32'h000A, spv);
        chk("call_abs_stk", 32'h054326, {stk[8'h08], stk[8'h09], stk[8'h0A]});
        rd(`REG_TARGET, d); chk("target", 32'h123456, d);
        chk("call_flags", fw0, fwc);
        rf[3] = 8'h01;
        go("decrement_branch_op_zero", 40'h10DB, 24'h001000, 1'b0);
        chk("decrement_branch_op_zero", 32'h00001002, {rf[3], pcv});
        go("decrement_branch_op_wrap", 40'hF0DB, 24'h001000, 1'b0);
        chk("decrement_branch_op_wrap", 32'hFF000FF2, {rf[3], pcv});
        rd(`REG_STATUS, d); chk("status_taken", 32'h1, d[`ST_TAKEN_BIT]);
        dm[8'h90] = 8'h70;
        go("decrement_branch_op_dir", 40'h0590D5, 24'h002000, 1'b0);
        chk("decrement_branch_op_dir", 32'h6F002008, {dm[8'h90], pcv});
        close_out();
    end
endmodule // divide_loop_extcall_exec_tb
